// ### bench/cio_card_model.sv
`timescale 1ns/1ps
`default_nettype none

module cio_card_model (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic seated_i,
    input wire logic [1:0] sense_i,
    input wire logic detect_change_i,
    input wire logic flag_clear_i,
    output logic card_detect_a_o,
    output logic card_detect_b_o,
    output logic voltage_sense_a_o,
    output logic voltage_sense_b_o,
    output logic detect_change_flag_o
);
    // detect pins are pulled up, so an empty socket reads high on both
    assign card_detect_a_o = seated_i ? 1'b0 : 1'b1;
    assign card_detect_b_o = seated_i ? 1'b0 : 1'b1;
    assign voltage_sense_a_o = sense_i[0];
    assign voltage_sense_b_o = sense_i[1];

    // status logic sets the flag one cycle after the change pulse
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            detect_change_flag_o <= 1'b0;
        end else if (detect_change_i) begin
            detect_change_flag_o <= 1'b1;
        end else if (flag_clear_i) begin
            detect_change_flag_o <= 1'b0;
        end
    end
endmodule : cio_card_model

`default_nettype wire

// ### bench/cio_window_detect_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

module cio_window_detect_regs_test;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    cio_pkg::cio_reg_req_type req = '0;
    logic irq_en = 1'b0;
    logic seated = 1'b0;
    logic [1:0] sense = 2'h2;
    logic flag_clr = 1'b0;
    logic [7:0] rdata;
    logic soft_irq, change, compat, ring, cd_a, cd_b, vs_a, vs_b, flag;
    logic [15:0] off0, off1;
    int miscompares = 0;
    int checked = 0;
    int n_irq = 0;
    int n_chg = 0;
    int n_rst = 0;

    cio_window_detect_regs dut (
        .CLOCK_I(clk), .NRST_I(nrst), .REG_REQ_I(req), .REG_RDATA_O(rdata),
        .CARD_DETECT_A_I(cd_a), .CARD_DETECT_B_I(cd_b), .VOLTAGE_SENSE_A_I(vs_a),
        .VOLTAGE_SENSE_B_I(vs_b), .DETECT_IRQ_ENABLE_I(irq_en), .DETECT_CHANGE_FLAG_I(flag),
        .SOFT_DETECT_IRQ_O(soft_irq), .DETECT_CHANGE_O(change), .COMPAT_RESET_O(compat),
        .RING_INDICATE_OUT_O(ring), .IO_OFFSET0_O(off0), .IO_OFFSET1_O(off1)
    );

    cio_card_model card (
        .clock_i(clk), .nrst_i(nrst), .seated_i(seated), .sense_i(sense),
        .detect_change_i(change), .flag_clear_i(flag_clr), .card_detect_a_o(cd_a),
        .card_detect_b_o(cd_b), .voltage_sense_a_o(vs_a), .voltage_sense_b_o(vs_b),
        .detect_change_flag_o(flag)
    );

    initial begin
        forever #20 clk = ~clk;
    end

    // pulse outputs are counted so their number and width can be judged
    always @(posedge clk) begin
        if (soft_irq === 1'b1) n_irq++;
        if (change === 1'b1) n_chg++;
        if (compat === 1'b1) n_rst++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask : check

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(posedge clk);
        #1;
        req.wr = 1'b0;
    endtask : wr

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1;
        req.addr = a;
        req.rd = 1'b1;
        @(posedge clk);
        #1;
        req.rd = 1'b0;
        check({8'h00, rdata}, {8'h00, exp});
    endtask : rd_check

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values;
        rd_check(8'h36, 8'h00);
        rd_check(8'h37, 8'h00);
        rd_check(8'h38, 8'h00);
        rd_check(8'h39, 8'h00);
        check(off0 | off1, 16'h0000);
        check({15'h0000, ring}, 16'h0001);
    endtask : t_reset_values

    task automatic t_windows;
        wr(8'h36, 8'hFF);
        wr(8'h37, 8'hA5);
        wr(8'h38, 8'h55);
        wr(8'h39, 8'h3C);
        wr(8'h17, 8'hFF);
        rd_check(8'h36, 8'hFE);
        rd_check(8'h37, 8'hA5);
        rd_check(8'h38, 8'h54);
        rd_check(8'h39, 8'h3C);
        rd_check(8'h17, 8'h00);
        check(off0, 16'hA5FE);
        check(off1, 16'h3C54);
        wr(8'h36, 8'h01);
        check(off0, 16'hA500);
    endtask : t_windows

    task automatic t_control;
        sense = 2'h1;
        cycles(4);
        wr(8'h16, 8'hFF);
        cycles(2);
        check(n_irq[15:0], 16'h0000);
        rd_check(8'h16, 8'h52);
        sense = 2'h2;
        cycles(4);
        rd_check(8'h16, 8'h92);
        wr(8'h16, 8'h00);
    endtask : t_control

    task automatic t_soft_irq;
        irq_en = 1'b1;
        wr(8'h16, 8'h20);
        wr(8'h16, 8'h20);
        cycles(2);
        check(n_irq[15:0], 16'h0002);
        irq_en = 1'b0;
        rd_check(8'h16, 8'h80);
    endtask : t_soft_irq

    task automatic t_ring;
        int chg0;
        chg0 = n_chg;
        wr(8'h16, 8'h10);
        seated = 1'b1;
        for (int i = 0; i < 12 && ring !== 1'b0; i++) @(posedge clk);
        #1;
        check({15'h0000, ring}, 16'h0000);
        cycles(6);
        check(n_chg[15:0] - chg0[15:0], 16'h0001);
        check({15'h0000, ring}, 16'h0000);
        flag_clr = 1'b1;
        cycles(1);
        flag_clr = 1'b0;
        cycles(3);
        check({15'h0000, ring}, 16'h0001);
        wr(8'h16, 8'h00);
        seated = 1'b0;
        cycles(8);
        check({15'h0000, ring}, 16'h0001);
        flag_clr = 1'b1;
        cycles(1);
        flag_clr = 1'b0;
    endtask : t_ring

    task automatic t_removal;
        wr(8'h16, 8'h02);
        seated = 1'b1;
        cycles(8);
        wr(8'h37, 8'h12);
        wr(8'h39, 8'h34);
        seated = 1'b0;
        cycles(8);
        check(off0 | off1, 16'h0000);
        check(n_rst[15:0], 16'h0001);
        wr(8'h16, 8'h00);
        seated = 1'b1;
        cycles(8);
        wr(8'h37, 8'h12);
        seated = 1'b0;
        cycles(8);
        check(off0, 16'h1200);
        check(n_rst[15:0], 16'h0001);
    endtask : t_removal

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        #1;
        nrst = 1'b1;
        cycles(3);
        t_reset_values();
        t_windows();
        t_control();
        t_soft_irq();
        t_ring();
        t_removal();
        finish_test();
    end

    // the whole sequence takes under two hundred cycles
    initial begin
        #(40 * 5000);
        miscompares++;
        finish_test();
    end
endmodule : cio_window_detect_regs_test

`default_nettype wire

// ### src/cio_pkg.sv
package cio_pkg;

    // register indices within the socket register space
    localparam logic [7:0] CIO_IDX_DETECT_CTRL = 8'h16;
    localparam logic [7:0] CIO_IDX_WIN0_LOW = 8'h36;
    localparam logic [7:0] CIO_IDX_WIN0_HIGH = 8'h37;
    localparam logic [7:0] CIO_IDX_WIN1_LOW = 8'h38;
    localparam logic [7:0] CIO_IDX_WIN1_HIGH = 8'h39;

    // card detect and general control field positions
    localparam int CIO_BIT_SENSE2_LEVEL = 7;
    localparam int CIO_BIT_SENSE1_LEVEL = 6;
    localparam int CIO_BIT_SOFT_DETECT_IRQ_TRIGGER = 5;
    localparam int CIO_BIT_DETECT_WAKE_ENABLE = 4;
    localparam int CIO_BIT_CLEAR_ON_REMOVAL = 1;

    // window low byte: bit 0 is hard zero
    localparam int CIO_BIT_WIN_LOW_ZERO = 0;
    localparam logic [7:0] CIO_WIN_LOW_MASK = 8'hFE;

    // reset values
    localparam logic [7:0] CIO_RST_WIN_BYTE = 8'h00;
    localparam logic CIO_RST_WAKE_ENABLE = 1'b0;
    localparam logic CIO_RST_CLEAR_ON_REMOVAL = 1'b0;
    localparam logic [7:0] CIO_RST_RDATA = 8'h00;
    localparam logic [1:0] CIO_RST_DETECT = 2'h3;
    localparam logic [1:0] CIO_RST_SENSE = 2'h0;
    localparam logic CIO_RING_IDLE_LEVEL = 1'b1;

    // number of I/O windows
    localparam int CIO_NUM_WINDOWS = 2;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } cio_reg_req_type;

    typedef enum logic [1:0] {
        CIO_RING_IDLE = 2'b00,
        CIO_RING_WAIT_SET = 2'b01,
        CIO_RING_HELD = 2'b10
    } cio_ring_state_type;

endpackage : cio_pkg

// ### src/cio_window_detect_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - low byte registers give offset bits 7..0
// - low byte bit 0 reads zero always
// - high byte registers give bits 15..8
// - each window keeps its own 16-bit offset
// - bit 7 shows live second sense pin
// - bit 6 shows live first sense pin
// - writing bit 5 raises detect irq if enabled
// - bit 5 write does nothing when disabled
// - bit 5 is write-only, reads zero
// - wake enable drives ring low on change
// - ring stays low until change flag cleared
// - wake disabled leaves ring untouched
// - bits 3, 2, 0 read zero, ignore writes
// - bit 1 resets registers on card removal
module cio_window_detect_regs (
    input wire logic CLOCK_I,
    input wire logic NRST_I,
    input wire cio_pkg::cio_reg_req_type REG_REQ_I,
    output logic [7:0] REG_RDATA_O,
    input wire logic CARD_DETECT_A_I,
    input wire logic CARD_DETECT_B_I,
    input wire logic VOLTAGE_SENSE_A_I,
    input wire logic VOLTAGE_SENSE_B_I,
    input wire logic DETECT_IRQ_ENABLE_I,
    input wire logic DETECT_CHANGE_FLAG_I,
    output logic SOFT_DETECT_IRQ_O,
    output logic DETECT_CHANGE_O,
    output logic COMPAT_RESET_O,
    output logic RING_INDICATE_OUT_O,
    output logic [15:0] IO_OFFSET0_O,
    output logic [15:0] IO_OFFSET1_O
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] detect_meta;
    logic [1:0] detect_sync;
    logic [1:0] detect_prev;
    logic [1:0] sense_meta;
    logic [1:0] sense_sync;

    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            detect_meta <= cio_pkg::CIO_RST_DETECT;
            detect_sync <= cio_pkg::CIO_RST_DETECT;
            detect_prev <= cio_pkg::CIO_RST_DETECT;
        end else begin
            detect_meta <= {CARD_DETECT_B_I, CARD_DETECT_A_I};
            detect_sync <= detect_meta;
            detect_prev <= detect_sync;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            sense_meta <= cio_pkg::CIO_RST_SENSE;
            sense_sync <= cio_pkg::CIO_RST_SENSE;
        end else begin
            sense_meta <= {VOLTAGE_SENSE_B_I, VOLTAGE_SENSE_A_I};
            sense_sync <= sense_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // change and removal detection
    logic detect_changed;
    logic card_removed;

    // detect pins are active low: card seated when both read low
    assign detect_changed = (detect_sync != detect_prev);
    assign card_removed = (detect_prev == 2'h0) && (detect_sync != 2'h0);

    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            DETECT_CHANGE_O <= 1'b0;
        end else begin
            DETECT_CHANGE_O <= detect_changed;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register
    logic detect_wake_enable;
    logic clear_on_removal;
    logic ctrl_write;

    assign ctrl_write = REG_REQ_I.wr && (REG_REQ_I.addr == cio_pkg::CIO_IDX_DETECT_CTRL);

    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            detect_wake_enable <= cio_pkg::CIO_RST_WAKE_ENABLE;
            clear_on_removal <= cio_pkg::CIO_RST_CLEAR_ON_REMOVAL;
        end else if (ctrl_write) begin
            detect_wake_enable <= REG_REQ_I.wdata[cio_pkg::CIO_BIT_DETECT_WAKE_ENABLE];
            clear_on_removal <= REG_REQ_I.wdata[cio_pkg::CIO_BIT_CLEAR_ON_REMOVAL];
        end
    end

    // write-only trigger, no storage behind it
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            SOFT_DETECT_IRQ_O <= 1'b0;
        end else begin
            SOFT_DETECT_IRQ_O <= ctrl_write && DETECT_IRQ_ENABLE_I
                && REG_REQ_I.wdata[cio_pkg::CIO_BIT_SOFT_DETECT_IRQ_TRIGGER];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            COMPAT_RESET_O <= 1'b0;
        end else begin
            COMPAT_RESET_O <= card_removed && clear_on_removal;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // I/O window offset registers
    logic [7:0] win_low [cio_pkg::CIO_NUM_WINDOWS];
    logic [7:0] win_high [cio_pkg::CIO_NUM_WINDOWS];
    logic [7:0] low_idx [cio_pkg::CIO_NUM_WINDOWS];
    logic [7:0] high_idx [cio_pkg::CIO_NUM_WINDOWS];

    assign low_idx[0] = cio_pkg::CIO_IDX_WIN0_LOW;
    assign low_idx[1] = cio_pkg::CIO_IDX_WIN1_LOW;
    assign high_idx[0] = cio_pkg::CIO_IDX_WIN0_HIGH;
    assign high_idx[1] = cio_pkg::CIO_IDX_WIN1_HIGH;

    generate
        for (genvar w = 0; w < cio_pkg::CIO_NUM_WINDOWS; w++) begin : g_win
            // removal reset wins over a same-cycle write
            always_ff @(posedge CLOCK_I) begin
                if (!NRST_I) begin
                    win_low[w] <= cio_pkg::CIO_RST_WIN_BYTE;
                    win_high[w] <= cio_pkg::CIO_RST_WIN_BYTE;
                end else if (card_removed && clear_on_removal) begin
                    win_low[w] <= cio_pkg::CIO_RST_WIN_BYTE;
                    win_high[w] <= cio_pkg::CIO_RST_WIN_BYTE;
                end else if (REG_REQ_I.wr) begin
                    if (REG_REQ_I.addr == low_idx[w]) begin
                        win_low[w] <= REG_REQ_I.wdata & cio_pkg::CIO_WIN_LOW_MASK;
                    end
                    if (REG_REQ_I.addr == high_idx[w]) begin
                        win_high[w] <= REG_REQ_I.wdata;
                    end
                end
            end
        end
    endgenerate

    assign IO_OFFSET0_O = {win_high[0], win_low[0]};
    assign IO_OFFSET1_O = {win_high[1], win_low[1]};

    ////////////////////////////////////////////////////////////////////////
    // ring indicate
    cio_pkg::cio_ring_state_type ring_state;
    cio_pkg::cio_ring_state_type next_ring_state;

    // the flag is set by the status logic a cycle or more after our pulse,
    // so wait to see it set before treating its low level as a clear
    always_comb begin
        next_ring_state = ring_state;
        unique case (ring_state)
            cio_pkg::CIO_RING_IDLE: begin
                if (DETECT_CHANGE_O && detect_wake_enable) begin
                    next_ring_state = cio_pkg::CIO_RING_WAIT_SET;
                end
            end
            cio_pkg::CIO_RING_WAIT_SET: begin
                if (DETECT_CHANGE_FLAG_I) begin
                    next_ring_state = cio_pkg::CIO_RING_HELD;
                end
            end
            cio_pkg::CIO_RING_HELD: begin
                if (!DETECT_CHANGE_FLAG_I) begin
                    next_ring_state = cio_pkg::CIO_RING_IDLE;
                end
            end
            default: begin
                next_ring_state = cio_pkg::CIO_RING_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            ring_state <= cio_pkg::CIO_RING_IDLE;
            RING_INDICATE_OUT_O <= cio_pkg::CIO_RING_IDLE_LEVEL;
        end else begin
            ring_state <= next_ring_state;
            RING_INDICATE_OUT_O <= (next_ring_state == cio_pkg::CIO_RING_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        unique case (REG_REQ_I.addr)
            cio_pkg::CIO_IDX_DETECT_CTRL: begin
                next_rdata[cio_pkg::CIO_BIT_SENSE2_LEVEL] = sense_sync[1];
                next_rdata[cio_pkg::CIO_BIT_SENSE1_LEVEL] = sense_sync[0];
                next_rdata[cio_pkg::CIO_BIT_DETECT_WAKE_ENABLE] = detect_wake_enable;
                next_rdata[cio_pkg::CIO_BIT_CLEAR_ON_REMOVAL] = clear_on_removal;
            end
            cio_pkg::CIO_IDX_WIN0_LOW: next_rdata = win_low[0];
            cio_pkg::CIO_IDX_WIN0_HIGH: next_rdata = win_high[0];
            cio_pkg::CIO_IDX_WIN1_LOW: next_rdata = win_low[1];
            cio_pkg::CIO_IDX_WIN1_HIGH: next_rdata = win_high[1];
            default: next_rdata = 8'h00;
        endcase
    end

    // read data holds until the next read
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            REG_RDATA_O <= cio_pkg::CIO_RST_RDATA;
        end else if (REG_REQ_I.rd) begin
            REG_RDATA_O <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!NRST_I);

    sequence s_ctrl_read;
        REG_REQ_I.rd && (REG_REQ_I.addr == cio_pkg::CIO_IDX_DETECT_CTRL);
    endsequence

    sequence s_wake_change;
        DETECT_CHANGE_O && detect_wake_enable && (ring_state == cio_pkg::CIO_RING_IDLE);
    endsequence

    sequence s_flag_cycle;
        DETECT_CHANGE_FLAG_I ##1 !DETECT_CHANGE_FLAG_I;
    endsequence

    AST_LOW_READ: assert property (
        REG_REQ_I.rd && (REG_REQ_I.addr == cio_pkg::CIO_IDX_WIN1_LOW)
            |=> REG_RDATA_O == $past(IO_OFFSET1_O[7:0]))
        else $error("window 1 low byte read mismatch");

    AST_LOW_BIT_ZERO: assert property (
        !IO_OFFSET0_O[cio_pkg::CIO_BIT_WIN_LOW_ZERO] && !IO_OFFSET1_O[cio_pkg::CIO_BIT_WIN_LOW_ZERO])
        else $error("window offset is odd");

    AST_HIGH_WRITE: assert property (
        REG_REQ_I.wr && (REG_REQ_I.addr == cio_pkg::CIO_IDX_WIN0_HIGH) && !(card_removed && clear_on_removal)
            |=> IO_OFFSET0_O[15:8] == $past(REG_REQ_I.wdata))
        else $error("window 0 high byte not stored");

    AST_WINDOWS_SEPARATE: assert property (
        REG_REQ_I.wr && (REG_REQ_I.addr == cio_pkg::CIO_IDX_WIN0_LOW) && !card_removed
            |=> $stable(IO_OFFSET1_O))
        else $error("window 0 write disturbed window 1");

    AST_SENSE_LEVELS: assert property (
        s_ctrl_read |=> REG_RDATA_O[7:6] == $past(sense_sync))
        else $error("sense levels not reported");

    AST_SOFT_IRQ: assert property (
        ctrl_write && DETECT_IRQ_ENABLE_I && REG_REQ_I.wdata[cio_pkg::CIO_BIT_SOFT_DETECT_IRQ_TRIGGER]
            |=> SOFT_DETECT_IRQ_O ##1 (!SOFT_DETECT_IRQ_O
                || $past(ctrl_write && DETECT_IRQ_ENABLE_I
                    && REG_REQ_I.wdata[cio_pkg::CIO_BIT_SOFT_DETECT_IRQ_TRIGGER])))
        else $error("soft detect irq missing");

    AST_SOFT_IRQ_OFF: assert property (
        !DETECT_IRQ_ENABLE_I |=> !SOFT_DETECT_IRQ_O)
        else $error("soft detect irq while disabled");

    AST_CTRL_ZERO_BITS: assert property (
        s_ctrl_read |=> (REG_RDATA_O[5] == 1'b0) && (REG_RDATA_O[3:2] == 2'h0) && (REG_RDATA_O[0] == 1'b0))
        else $error("zero bits of control register read set");

    AST_RING_FALL: assert property (
        s_wake_change |=> !RING_INDICATE_OUT_O)
        else $error("ring indicate not driven low");

    AST_RING_HOLD: assert property (
        !RING_INDICATE_OUT_O ##0 s_flag_cycle |-> ##1 RING_INDICATE_OUT_O)
        else $error("ring indicate not released after flag clear");

    AST_RING_KEEP: assert property (
        !RING_INDICATE_OUT_O && DETECT_CHANGE_FLAG_I |=> !RING_INDICATE_OUT_O)
        else $error("ring indicate released while flag set");

    AST_RING_DISABLED: assert property (
        (ring_state == cio_pkg::CIO_RING_IDLE) && !detect_wake_enable |=> RING_INDICATE_OUT_O)
        else $error("ring indicate moved while wake disabled");

    AST_REMOVAL_RESET: assert property (
        card_removed && clear_on_removal |=> (IO_OFFSET0_O == 16'h0000) && (IO_OFFSET1_O == 16'h0000)
            && COMPAT_RESET_O)
        else $error("removal did not reset registers");

    AST_REMOVAL_KEEP: assert property (
        !clear_on_removal && !REG_REQ_I.wr |=> $stable(IO_OFFSET0_O) && !COMPAT_RESET_O)
        else $error("registers changed on removal while disabled");

    AST_CHANGE_PULSE: assert property (
        detect_sync != detect_prev |=> DETECT_CHANGE_O)
        else $error("detect change pulse missing");

endmodule : cio_window_detect_regs

`default_nettype wire
